//--- logic/write_buffer_cmd_decoder.sv
// write buffer command decoder with apb register access
`timescale 1ns/100ps
module write_buffer_cmd_decoder #(
  parameter int SAVE_CYCLES = wb_pkg::SAVE_LIMIT_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire wb_pkg::apb_in_type apb_in,
  output wb_pkg::apb_out_type apb_out,
  // cache and flash side
  output logic cache_flush,
  output logic flash_write,
  input wire logic flash_done,
  output logic por_request
);
  import wb_pkg::*;

  typedef struct packed {
    fsm_type st;
    logic [2:0][31:0] cdb;
    logic [2:0] initiator;
    logic [23:0] cnt;
    logic [9:0] wptr;
    logic [9:0] peek;
    logic [TMR_W-1:0] tmr;
    logic busy;
    logic done;
    logic chk;
    logic [3:0] skey;
    logic [7:0] asc;
    logic [7:0] ua;
    logic ucode_live;
    logic save_pend;
    logic [2:0] sync;
    logic flush;
    logic flash_wr;
    logic por_req;
    apb_out_type apb;
    logic [BUF_BYTES-1:0][7:0] buf_mem;
    logic [IMAGE_BYTES-1:0][7:0] code_mem;
  } regs_type;

  regs_type r;
  regs_type next_r;
  cmd_type c;
  logic access;
  logic wr_ok;
  logic start_take;
  logic data_push;
  logic flash_seen;
  logic mode_ok;

  assign c = decode_cdb(r.cdb);
  assign access = apb_in.psel & apb_in.penable;
  assign wr_ok = access & r.apb.pready & apb_in.pwrite;
  assign start_take = wr_ok & (apb_in.paddr == REG_CTRL)
    & apb_in.pwdata[CTRL_START] & ~r.busy;
  assign data_push = wr_ok & (apb_in.paddr == REG_DATA)
    & (r.st == ST_XFER);
  // second and third stage must agree
  assign flash_seen = r.sync[1] & r.sync[2];

  always_comb begin
    logic err;
    logic nolen;
    logic [24:0] span;
    logic [31:0] rd;
    logic [23:0] cnt1;
    logic [7:0] uset;
    err = 1'b0;
    nolen = 1'b0;
    span = {1'b0, c.offset} + {1'b0, c.length};
    rd = 32'h0000_0000;
    cnt1 = r.cnt + 24'h000001;
    uset = 8'h00;
    mode_ok = 1'b1;
    next_r = r;
    next_r.flush = 1'b0;
    next_r.por_req = 1'b0;
    next_r.sync = {r.sync[1:0], flash_done};
    unique case (apb_in.paddr)
      REG_CDB0: rd = r.cdb[0];
      REG_CDB1: rd = r.cdb[1];
      REG_CDB2: rd = r.cdb[2];
      REG_CTRL: rd = {28'h0000000, r.initiator, 1'b0};
      REG_STATUS: rd = {13'h0000, r.flash_wr, r.save_pend, r.ucode_live,
        r.asc, r.skey, 1'b0, r.chk, r.done, r.busy};
      REG_UA: rd = {24'h000000, r.ua};
      REG_PEEK: rd = {24'h000000, r.buf_mem[r.peek]};
      default: rd = 32'h0000_0000;
    endcase
    // one wait state so read data leaves a flip-flop
    if (access & ~r.apb.pready) begin
      next_r.apb.pready = 1'b1;
      next_r.apb.prdata = rd;
      next_r.apb.pslverr = ~(apb_in.paddr inside {REG_CDB0, REG_CDB1,
        REG_CDB2, REG_CTRL, REG_DATA, REG_STATUS, REG_UA, REG_PEEK});
    end else begin
      next_r.apb.pready = 1'b0;
      next_r.apb.pslverr = 1'b0;
    end
    if (wr_ok & ~r.busy) begin
      if (apb_in.paddr == REG_CDB0) next_r.cdb[0] = apb_in.pwdata;
      if (apb_in.paddr == REG_CDB1) next_r.cdb[1] = apb_in.pwdata;
      if (apb_in.paddr == REG_CDB2) next_r.cdb[2] = apb_in.pwdata;
    end
    if (wr_ok & (apb_in.paddr == REG_PEEK)) begin
      next_r.peek = apb_in.pwdata[9:0];
    end
    unique case (r.st)
      ST_IDLE: begin
        if (start_take) begin
          next_r.initiator = apb_in.pwdata[CTRL_INIT_LSB +: 3];
          next_r.flush = 1'b1;
          next_r.asc = ASC_INV_CDB;
          if (c.op != OPC_WRITE_BUF) begin
            err = 1'b1;
            next_r.asc = ASC_INV_OPC;
          end else begin
            unique case (c.mode)
              MODE_HDR_DATA: begin
                err = (c.buf_id != 8'h00) || (c.offset != 24'h000000)
                  || (c.length > 24'(BUF_BYTES));
                nolen = c.length < HDR_BYTES;
              end
              MODE_DATA: begin
                err = (c.buf_id != 8'h00)
                  || (c.offset >= 24'(BUF_BYTES))
                  || (span >= 25'(BUF_BYTES))
                  || (c.length % 24'(SECTOR_BYTES) != 24'h000000);
                nolen = c.length == 24'h000000;
              end
              MODE_UCODE: begin
                err = ((c.buf_id != 8'h00) && (c.buf_id != VENDOR_AREA_ID))
                  || (c.offset != 24'h000000)
                  || ((c.length != 24'(IMAGE_BYTES))
                  && (c.length != 24'h000000));
                nolen = c.length == 24'h000000;
              end
              MODE_UCODE_SAVE: begin
                err = (c.buf_id != 8'h00) || (c.offset != 24'h000000)
                  || ((c.length != 24'(IMAGE_BYTES))
                  && (c.length != 24'h000000));
                nolen = c.length == 24'h000000;
              end
              MODE_OFS_SAVE, MODE_ECHO, MODE_SEL_DEFER, MODE_DEFER,
              MODE_ACTIVATE, MODE_EXPANDER: nolen = 1'b1;
              default: begin
                err = 1'b1;
                mode_ok = 1'b0;
              end
            endcase
          end
          next_r.chk = err;
          next_r.skey = err ? SK_ILLEGAL : 4'h0;
          next_r.cnt = 24'h000000;
          next_r.wptr = (c.mode == MODE_DATA) ? c.offset[9:0] : 10'h000;
          if (err | nolen) begin
            next_r.done = 1'b1;
            next_r.busy = 1'b0;
          end else begin
            next_r.done = 1'b0;
            next_r.busy = 1'b1;
            next_r.st = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        if (data_push) begin
          next_r.cnt = cnt1;
          // header bytes are counted but dropped
          if ((c.mode != MODE_HDR_DATA) || (r.cnt >= HDR_BYTES)) begin
            next_r.wptr = r.wptr + 10'h001;
            // only the buffer or code store is written, never media
            if ((c.mode == MODE_DATA) || (c.mode == MODE_HDR_DATA)) begin
              next_r.buf_mem[r.wptr] = apb_in.pwdata[7:0];
            end else begin
              next_r.code_mem[r.wptr[7:0]] = apb_in.pwdata[7:0];
            end
          end
          if (cnt1 == c.length) begin
            if (c.mode == MODE_UCODE) begin
              next_r.ucode_live = 1'b1;
              uset = ~(8'h01 << r.initiator);
              next_r.done = 1'b1;
              next_r.busy = 1'b0;
              next_r.st = ST_IDLE;
            end else if (c.mode == MODE_UCODE_SAVE) begin
              if (r.code_mem[0] != BOOT_COMPAT_TAG) begin
                next_r.chk = 1'b1;
                next_r.skey = SK_ILLEGAL;
                next_r.asc = ASC_INV_PARM;
                next_r.done = 1'b1;
                next_r.busy = 1'b0;
                next_r.st = ST_IDLE;
              end else begin
                next_r.flash_wr = 1'b1;
                next_r.tmr = '0;
                next_r.st = ST_SAVE;
              end
            end else begin
              next_r.done = 1'b1;
              next_r.busy = 1'b0;
              next_r.st = ST_IDLE;
            end
          end
        end
      end
      ST_SAVE: begin
        next_r.tmr = r.tmr + 1'b1;
        if (flash_seen) begin
          next_r.flash_wr = 1'b0;
          next_r.save_pend = 1'b1;
          next_r.por_req = 1'b1;
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.st = ST_IDLE;
        end else if (r.tmr == TMR_W'(SAVE_CYCLES - 1)) begin
          next_r.flash_wr = 1'b0;
          next_r.chk = 1'b1;
          next_r.skey = SK_HW_ERR;
          next_r.asc = ASC_TIMEOUT;
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.st = ST_IDLE;
        end
      end
    endcase
    // write one to clear; a new attention wins
    if (wr_ok & (apb_in.paddr == REG_UA)) begin
      next_r.ua = r.ua & ~apb_in.pwdata[7:0];
    end
    next_r.ua = next_r.ua | uset;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign apb_out = r.apb;
  assign cache_flush = r.flush;
  assign flash_write = r.flash_wr;
  assign por_request = r.por_req;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_opcode_reject: assert property (
    start_take && c.op != OPC_WRITE_BUF |=> r.chk && r.asc == ASC_INV_OPC)
    else $error("foreign opcode not rejected");
  a_mode_reject: assert property (
    start_take && c.op == OPC_WRITE_BUF && !mode_ok
    |=> r.chk && r.skey == SK_ILLEGAL && r.asc == ASC_INV_CDB && !r.busy)
    else $error("unlisted mode not rejected");
  a_cache_flush: assert property (
    start_take |=> cache_flush ##1 !cache_flush)
    else $error("cache flush not one pulse per command");
  a_header_drop: assert property (
    data_push && c.mode == MODE_HDR_DATA && r.cnt < HDR_BYTES
    |=> r.wptr == $past(r.wptr))
    else $error("header byte stored");
  a_header_id: assert property (
    start_take && c.op == OPC_WRITE_BUF && c.mode == MODE_HDR_DATA
    && c.buf_id != 8'h00 |=> r.chk && !r.busy)
    else $error("nonzero header id accepted");
  a_short_header: assert property (
    start_take && c.op == OPC_WRITE_BUF && c.mode == MODE_HDR_DATA
    && c.buf_id == 8'h00 && c.offset == 24'h000000 && c.length < HDR_BYTES
    |=> r.done && !r.chk && r.st == ST_IDLE)
    else $error("short header length moved data");
  a_data_offset: assert property (
    start_take && c.op == OPC_WRITE_BUF && c.mode == MODE_DATA
    && c.offset >= 24'(BUF_BYTES) |=> r.chk && r.skey == SK_ILLEGAL)
    else $error("offset beyond buffer accepted");
  a_ucode_offset: assert property (
    start_take && c.op == OPC_WRITE_BUF && c.mode == MODE_UCODE
    && c.offset != 24'h000000 |=> r.chk && r.asc == ASC_INV_CDB)
    else $error("nonzero code offset accepted");
  a_ua_others: assert property (
    data_push && c.mode == MODE_UCODE && r.cnt + 24'h000001 == c.length
    |=> r.ucode_live && r.ua[r.initiator] == $past(r.ua[r.initiator]))
    else $error("unit attention posted to issuer");
  a_save_reset: assert property (
    $rose(por_request) |-> $past(r.st == ST_SAVE) && r.save_pend)
    else $error("reset request without a finished save");
  a_save_bound: assert property (
    r.st == ST_SAVE |-> r.tmr < TMR_W'(SAVE_CYCLES))
    else $error("saved update overran its time");

  c_data_done: cover property (
    r.st == ST_XFER && c.mode == MODE_DATA ##1 r.st == ST_IDLE && !r.chk);
  c_ucode_live: cover property ($rose(r.ucode_live));
  c_save_ok: cover property ($rose(por_request));
  c_save_timeout: cover property (r.st == ST_SAVE ##1 r.asc == ASC_TIMEOUT);
endmodule : write_buffer_cmd_decoder

//--- logic/wb_pkg.sv
// constants, types and decoding shared by the write buffer decoder
package wb_pkg;
  localparam logic [7:0] OPC_WRITE_BUF = 8'h3B;
  localparam logic [4:0] MODE_HDR_DATA = 5'h00;
  localparam logic [4:0] MODE_DATA = 5'h02;
  localparam logic [4:0] MODE_UCODE = 5'h04;
  localparam logic [4:0] MODE_UCODE_SAVE = 5'h05;
  localparam logic [4:0] MODE_OFS_SAVE = 5'h07;
  localparam logic [4:0] MODE_ECHO = 5'h0A;
  localparam logic [4:0] MODE_SEL_DEFER = 5'h0D;
  localparam logic [4:0] MODE_DEFER = 5'h0E;
  localparam logic [4:0] MODE_ACTIVATE = 5'h0F;
  localparam logic [4:0] MODE_EXPANDER = 5'h1A;
  localparam int BUF_BYTES = 1024;
  localparam int SECTOR_BYTES = 512;
  localparam int IMAGE_BYTES = 256;
  localparam logic [23:0] HDR_BYTES = 24'h000004;
  localparam logic [7:0] VENDOR_AREA_ID = 8'h01; // arbitrary value
  localparam logic [7:0] BOOT_COMPAT_TAG = 8'hA5; // arbitrary value
  localparam logic [3:0] SK_ILLEGAL = 4'h5;
  localparam logic [3:0] SK_HW_ERR = 4'h4;
  localparam logic [7:0] ASC_INV_OPC = 8'h20;
  localparam logic [7:0] ASC_INV_CDB = 8'h24;
  localparam logic [7:0] ASC_INV_PARM = 8'h26;
  localparam logic [7:0] ASC_TIMEOUT = 8'h44;
  localparam logic [7:0] REG_CDB0 = 8'h00;
  localparam logic [7:0] REG_CDB1 = 8'h04;
  localparam logic [7:0] REG_CDB2 = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_UA = 8'h18;
  localparam logic [7:0] REG_PEEK = 8'h1C;
  localparam int CTRL_START = 0;
  localparam int CTRL_INIT_LSB = 1;
  localparam int SAVE_LIMIT_S = 30;
  localparam int CLK_HZ = 10_000_000;
  localparam int SAVE_LIMIT_CYCLES = SAVE_LIMIT_S * CLK_HZ;
  localparam int TMR_W = 29;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_SAVE = 3'b100
  } fsm_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_in_type;
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_out_type;
  typedef struct packed {
    logic [7:0] op;
    logic [2:0] mspec;
    logic [4:0] mode;
    logic [7:0] buf_id;
    logic [23:0] offset;
    logic [23:0] length;
  } cmd_type;
  // byte k of the descriptor sits in word k/4, lane k%4
  function automatic cmd_type decode_cdb(input logic [2:0][31:0] w);
    cmd_type c;
    c.op = w[0][7:0];
    c.mspec = w[0][15:13];
    c.mode = w[0][12:8];
    c.buf_id = w[0][23:16];
    c.offset = {w[0][31:24], w[1][7:0], w[1][15:8]};
    c.length = {w[1][23:16], w[1][31:24], w[2][7:0]};
    return c;
  endfunction : decode_cdb
endpackage : wb_pkg

//--- dv/flash_model.sv
// flash side responder for the save path
`timescale 1ns/100ps
module flash_model (
  // clock
  input wire logic pclk,
  // flash handshake
  input wire logic flash_write,
  input wire logic stall,
  output logic flash_done
);
  int cnt = 0;
  // done some cycles into the rewrite, dropped when write ends
  always @(posedge pclk) begin
    cnt <= flash_write ? cnt + 1 : 0;
    flash_done <= flash_write && !stall && cnt >= 5;
  end
endmodule : flash_model

//--- dv/tb_write_buffer_cmd_decoder.sv
// self-checking bench for the write buffer decoder
`timescale 1ns/100ps
module tb_write_buffer_cmd_decoder;
  import wb_pkg::*;
  localparam logic [12:0] ILL = {1'b1, SK_ILLEGAL, ASC_INV_CDB};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_in_type apb_in = '0;
  apb_out_type apb_out;
  logic cache_flush, flash_write, flash_done, por_request;
  logic stall = 1'b0;
  int fails = 0;
  int checked = 0;
  int flushes = 0;
  int starts = 0;
  int pors = 0;
  logic [31:0] rd;
  logic err;
  always #50 pclk = ~pclk;
  write_buffer_cmd_decoder #(.SAVE_CYCLES(200)) dut_u (.pclk(pclk),
    .presetn(presetn), .apb_in(apb_in), .apb_out(apb_out),
    .cache_flush(cache_flush), .flash_write(flash_write),
    .flash_done(flash_done), .por_request(por_request));
  flash_model part_u (.pclk(pclk), .flash_write(flash_write),
    .stall(stall), .flash_done(flash_done));
  always @(posedge pclk) begin
    flushes <= flushes + int'(cache_flush === 1'b1);
    pors <= pors + int'(por_request === 1'b1);
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic hung();
    fails++;
    $display("Error at %0t: wait ran out", $time);
    summarize();
  endtask : hung
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_in.psel <= 1'b1;
    apb_in.pwrite <= w;
    apb_in.paddr <= a;
    apb_in.pwdata <= d;
    @(posedge pclk);
    apb_in.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_out.pready !== 1'b1 && n < 20);
    if (n >= 20) hung();
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask : apb
  // poll until done, then compare check flag, plus key and code when a check is expected
  task automatic finish_cmd(input logic [12:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'b10 && n < 400);
    if (n >= 400) hung();
    if (exp[12]) check({rd[2], rd[7:4], rd[15:8]}, exp);
    else check({rd[2], 12'h0}, exp);
  endtask : finish_cmd
  task automatic cmd(input logic [7:0] op, input logic [4:0] mode,
                     input logic [7:0] id, input logic [23:0] ofs,
                     input logic [23:0] len, input int n,
                     input logic [7:0] first, input logic [12:0] exp);
    apb(1'b1, REG_CDB0, {ofs[23:16], id, 3'b000, mode, op});
    apb(1'b1, REG_CDB1, {len[15:8], len[23:16], ofs[7:0], ofs[15:8]});
    apb(1'b1, REG_CDB2, {24'h0, len[7:0]});
    apb(1'b1, REG_CTRL, 32'h7);
    starts++;
    for (int i = 0; i < n; i++) begin
      logic [7:0] b;
      b = (i == 0) ? first : 8'(i);
      if (mode == MODE_HDR_DATA && i < 4) b = 8'h00;
      apb(1'b1, REG_DATA, {24'h0, b});
    end
    finish_cmd(exp);
    check(flushes, starts);
  endtask : cmd
  task automatic peek(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b1, REG_PEEK, {22'h0, idx});
    apb(1'b0, REG_PEEK, 32'h0);
    check(rd[7:0], exp);
  endtask : peek
  initial begin
    logic [4:0] bad [4];
    logic [4:0] quiet [6];
    bad = '{5'h01, 5'h03, 5'h06, 5'h1F};
    quiet = '{MODE_OFS_SAVE, MODE_ECHO, MODE_SEL_DEFER, MODE_DEFER,
              MODE_ACTIVATE, MODE_EXPANDER};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("test unmapped done");
    foreach (bad[i]) cmd(OPC_WRITE_BUF, bad[i], 0, 0, 0, 0, 0, ILL);
    cmd(8'h2A, MODE_DATA, 0, 0, 0, 0, 0,
        {1'b1, SK_ILLEGAL, ASC_INV_OPC});
    foreach (quiet[i]) cmd(OPC_WRITE_BUF, quiet[i], 0, 0, 0, 0, 0, 0);
    $display("test mode decode done");
    cmd(OPC_WRITE_BUF, MODE_HDR_DATA, 1, 0, 8, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_HDR_DATA, 0, 1, 8, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_HDR_DATA, 0, 0, 1025, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_HDR_DATA, 0, 0, 2, 0, 0, 0);
    cmd(OPC_WRITE_BUF, MODE_HDR_DATA, 0, 0, 8, 8, 0, 0);
    peek(0, 8'h04);
    peek(3, 8'h07);
    $display("test header mode done");
    cmd(OPC_WRITE_BUF, MODE_DATA, 0, 0, 512, 512, 0, 0);
    peek(1, 8'h01);
    peek(511, 8'hFF);
    cmd(OPC_WRITE_BUF, MODE_DATA, 0, 256, 512, 512, 8'h5A, 0);
    peek(256, 8'h5A);
    peek(257, 8'h01);
    peek(767, 8'hFF);
    cmd(OPC_WRITE_BUF, MODE_DATA, 0, 0, 256, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_DATA, 0, 512, 512, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_DATA, 0, 1024, 512, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_DATA, 1, 0, 512, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_DATA, 0, 0, 0, 0, 0, 0);
    $display("test data mode done");
    apb(1'b0, REG_UA, 32'h0);
    check(rd[7:0], 8'h00);
    cmd(OPC_WRITE_BUF, MODE_UCODE, 0, 0, 256, 256, 0, 0);
    check(rd[16], 1'b1);
    apb(1'b0, REG_UA, 32'h0);
    check(rd[7:0], 8'hF7);
    apb(1'b1, REG_UA, 32'hFF);
    apb(1'b0, REG_UA, 32'h0);
    check(rd[7:0], 8'h00);
    cmd(OPC_WRITE_BUF, MODE_UCODE, 0, 1, 256, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_UCODE, 2, 0, 256, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_UCODE, 0, 0, 100, 0, 0, ILL);
    cmd(OPC_WRITE_BUF, MODE_UCODE, 0, 0, 0, 0, 0, 0);
    cmd(OPC_WRITE_BUF, MODE_UCODE, VENDOR_AREA_ID, 0, 256, 256, 0, 0);
    $display("test download done");
    cmd(OPC_WRITE_BUF, MODE_UCODE_SAVE, 0, 0, 256, 256,
        BOOT_COMPAT_TAG, 0);
    check(pors, 1);
    cmd(OPC_WRITE_BUF, MODE_UCODE_SAVE, 0, 0, 256, 256, 8'h00,
        {1'b1, SK_ILLEGAL, ASC_INV_PARM});
    stall <= 1'b1;
    cmd(OPC_WRITE_BUF, MODE_UCODE_SAVE, 0, 0, 256, 256, BOOT_COMPAT_TAG,
        {1'b1, SK_HW_ERR, ASC_TIMEOUT});
    stall <= 1'b0;
    check(pors, 1);
    $display("test save done");
    summarize();
  end
endmodule : tb_write_buffer_cmd_decoder
